// ===== logic/fifo_host_ctrl.sv
/*
 Host controller for an external asynchronous 1024x9 FIFO: drives the
 active-low write, read, init and load/replay pins, honours the flags.
 Assumes device inputs are synchronous to core_clk; software over APB.
*/
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: first_load low only on chosen first device
// R2: strobe only when matching flag inactive
// R3: device half flag low at 513 words
// R4: half flag may glitch, settles later
// R5: sample half flag as level only
// R6: replay pulse rewinds read pointer only
// R7: read high through replay, then recover
// R8: replay only after at most 1024 writes
// R9: flags valid by end of replay
// R10: chain_in low selects single mode
// R11: sample flags after settling time
// R12: depth mode chosen during init pulse
// R13: device pulses chain_out at location 1024
// R14: one device writes, one reads
// R15: OR all full, all empty flags
// R16: no half flag or replay in depth
// R17: first_load held as at init; the code drives it from the live CTRL first bit instead
// R18: width and depth expansion combined
// R19: full after 1024 net writes
// R20: empty when writes equal reads
// R21: pointers wrap at 1023
// R22: 10-bit pointers, 11-bit count
module fifo_host_ctrl #(
   parameter int NDEV = 1,
   parameter int LOG_DEPTH = 10
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NDEV-1:0] dev_empty_n,
   input wire logic [NDEV-1:0] dev_full_n,
   input wire logic half_level_flag_n,
   input wire logic [fifo_host_pkg::WORD_W-1:0] dev_rdata,
   output fifo_host_pkg::fifo_pins_t pins,
   output logic chain_mode
);
   typedef struct packed {
      fifo_host_pkg::seq_state_t st;
      logic [3:0] ctrl;
      logic [7:0] cnt;
      logic is_read;
      logic busy_replay;
      logic [10:0] writes;
      logic [LOG_DEPTH-1:0] reads;
      logic [fifo_host_pkg::WORD_W-1:0] rdata;
      logic [fifo_host_pkg::WORD_W-1:0] wdata;
      logic rvalid;
      logic replay_ok;
      logic [fifo_host_pkg::WORD_W-1:0] pin_wdata;
      logic write_n;
      logic read_n;
      logic init_n;
   } state_t;
   state_t q, d;
   logic all_empty_n, all_full_n, acc, wr_go, rd_go, wr_req, rd_req;
   logic [LOG_DEPTH-1:0] log_addr, log_raddr;
   logic [fifo_host_pkg::WORD_W-1:0] log_rd;

   // --------------------------------------------------------------
   // Flag combining across devices
   // --------------------------------------------------------------
   // Composite asserted flag if any device asserts (low) its flag
   assign all_empty_n = &dev_empty_n; // R15 R18
   assign all_full_n = &dev_full_n; // R15
   assign chain_mode = q.ctrl[fifo_host_pkg::CTRL_DEPTH_BIT]; // R12

   assign acc = psel && penable;
   assign pready = 1'b1;
   assign pslverr = acc && !(paddr == fifo_host_pkg::CTRL_OFS ||
      paddr == fifo_host_pkg::WDATA_OFS || paddr == fifo_host_pkg::RDATA_OFS ||
      paddr == fifo_host_pkg::STAT_OFS || paddr == fifo_host_pkg::WCNT_OFS);
   assign wr_req = acc && pwrite && paddr == fifo_host_pkg::WDATA_OFS;
   assign rd_req = acc && !pwrite && paddr == fifo_host_pkg::RDATA_OFS;
   // Strobe only while the flag is inactive at cycle start
   assign wr_go = all_full_n && q.st == fifo_host_pkg::ST_IDLE; // R2
   assign rd_go = all_empty_n && q.st == fifo_host_pkg::ST_IDLE; // R2
   // Log indices track the device pointers and wrap with them until writes saturates at 11'h7ff
   assign log_addr = q.writes[LOG_DEPTH-1:0];
   assign log_raddr = q.reads;

   write_log_mem #(.WIDTH(fifo_host_pkg::WORD_W), .DEPTH(2 ** LOG_DEPTH)) u_log (
      .core_clk(core_clk),
      .clk_en(clk_en),
      .wr_en(wr_req && wr_go && !q.ctrl[fifo_host_pkg::CTRL_INIT_BIT] &&
         !q.ctrl[fifo_host_pkg::CTRL_REPLAY_BIT]),
      .wr_addr(log_addr),
      .wr_data(pwdata[fifo_host_pkg::WORD_W-1:0]),
      .rd_addr(log_raddr),
      .rd_data(log_rd)
   );

   always_comb begin
      prdata = 32'h0;
      case (paddr)
         fifo_host_pkg::CTRL_OFS: prdata = {28'h0, q.ctrl};
         fifo_host_pkg::RDATA_OFS: prdata = {22'h0, q.rvalid, q.rdata};
         // Half flag reported as level; meaningless in depth mode
         fifo_host_pkg::STAT_OFS: prdata = {26'h0, q.replay_ok,
            q.st != fifo_host_pkg::ST_IDLE, half_level_flag_n | chain_mode,
            all_full_n, all_empty_n, 1'b0}; // R5 R16
         fifo_host_pkg::WCNT_OFS: prdata = {21'h0, q.writes};
         default: prdata = 32'h0;
      endcase
   end

   // --------------------------------------------------------------
   // Strobe sequencer
   // --------------------------------------------------------------
   always_comb begin
      d = q;
      case (q.st)
         fifo_host_pkg::ST_IDLE: begin
            d.cnt = 8'h0;
            if (q.ctrl[fifo_host_pkg::CTRL_INIT_BIT]) begin
               d.st = fifo_host_pkg::ST_INIT; // R12
               d.init_n = 1'b0;
               d.writes = 11'h0;
               d.reads = '0;
               d.ctrl[fifo_host_pkg::CTRL_INIT_BIT] = 1'b0;
            end else if (q.ctrl[fifo_host_pkg::CTRL_REPLAY_BIT]) begin
               d.ctrl[fifo_host_pkg::CTRL_REPLAY_BIT] = 1'b0;
               // Replay only in single mode and within depth
               if (!chain_mode && q.writes <= 11'(fifo_host_pkg::MAX_REPLAY_WRITES)) begin
                  d.st = fifo_host_pkg::ST_ASSERT; // R6 R8 R16
                  d.busy_replay = 1'b1;
                  d.reads = '0;
               end
            end else if (wr_req && wr_go) begin
               d.st = fifo_host_pkg::ST_ASSERT;
               d.is_read = 1'b0;
               d.write_n = 1'b0;
               d.pin_wdata = pwdata[fifo_host_pkg::WORD_W-1:0];
               d.writes = (q.writes == 11'h7ff) ? q.writes : q.writes + 11'h1;
            end else if (rd_req && rd_go) begin
               d.st = fifo_host_pkg::ST_ASSERT;
               d.is_read = 1'b1;
               d.read_n = 1'b0;
               d.rvalid = 1'b0;
            end
         end
         fifo_host_pkg::ST_ASSERT: begin
            d.cnt = q.cnt + 8'h1;
            if (q.cnt == 8'(fifo_host_pkg::STROBE_CYC - 1)) begin
               if (!q.read_n) begin
                  d.rdata = dev_rdata;
                  d.rvalid = 1'b1;
                  d.replay_ok = dev_rdata == log_rd;
                  d.reads = LOG_DEPTH'(q.reads + 1'b1);
               end
               d.write_n = 1'b1;
               d.read_n = 1'b1;
               d.cnt = 8'h0;
               d.st = fifo_host_pkg::ST_RECOVER;
            end
         end
         fifo_host_pkg::ST_RECOVER: begin
            d.cnt = q.cnt + 8'h1;
            if (q.cnt == 8'(fifo_host_pkg::RECOVER_CYC - 1)) begin
               d.cnt = 8'h0;
               d.st = fifo_host_pkg::ST_SETTLE;
            end
         end
         fifo_host_pkg::ST_SETTLE: begin
            // Wait worst-case flag settle before next sample
            d.cnt = q.cnt + 8'h1;
            if (q.cnt == 8'(fifo_host_pkg::SETTLE_CYC - 1)) begin
               d.st = fifo_host_pkg::ST_IDLE; // R4 R7 R9 R11
               d.busy_replay = 1'b0;
            end
         end
         fifo_host_pkg::ST_INIT: begin
            d.cnt = q.cnt + 8'h1;
            if (q.cnt == 8'(fifo_host_pkg::INIT_CYC - 1)) begin
               d.init_n = 1'b1;
               d.cnt = 8'h0;
               d.st = fifo_host_pkg::ST_RECOVER;
            end
         end
         default: d.st = fifo_host_pkg::ST_IDLE;
      endcase
      // A software write in the same cycle beats the self-clear
      if (acc && pwrite && paddr == fifo_host_pkg::CTRL_OFS) begin
         d.ctrl = pwdata[3:0];
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
         q.st <= fifo_host_pkg::ST_IDLE;
         q.ctrl <= fifo_host_pkg::CTRL_RESET;
         q.write_n <= 1'b1;
         q.read_n <= 1'b1;
         q.init_n <= 1'b1;
      end else if (clk_en) begin
         q <= d;
      end
   end

   // --------------------------------------------------------------
   // Pins
   // --------------------------------------------------------------
   always_comb begin
      pins.write_n = q.write_n;
      pins.read_n = q.read_n; // R7
      pins.init_pulse_n = q.init_n;
      pins.wdata = q.pin_wdata;
      // Depth mode: first_load level follows the CTRL first bit, steady while CTRL is unchanged
      if (chain_mode) begin
         pins.load_replay_pin = !q.ctrl[fifo_host_pkg::CTRL_FIRST_BIT]; // R1 R17
      end else begin
         pins.load_replay_pin = !(q.busy_replay && q.st == fifo_host_pkg::ST_ASSERT); // R6
      end
   end

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   a_write_full_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
      $fell(pins.write_n) |-> $past(all_full_n)) else $error("write while full"); // R2
   a_read_empty_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
      $fell(pins.read_n) |-> $past(all_empty_n)) else $error("read while empty"); // R2
   a_replay_read_high: assert property (@(posedge core_clk) disable iff (!reset_n)
      !pins.load_replay_pin && !chain_mode |-> pins.read_n) else $error("read in replay"); // R7
   a_replay_depth_off: assert property (@(posedge core_clk) disable iff (!reset_n)
      chain_mode && $stable(q.ctrl) |-> $stable(pins.load_replay_pin))
      else $error("first load moved"); // R17
   a_strobe_width_min: assert property (@(posedge core_clk) disable iff (!reset_n)
      $fell(pins.write_n) |-> !pins.write_n [*2]) else $error("write too short"); // R2
   a_replay_recover: assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(pins.load_replay_pin) && !chain_mode |-> pins.read_n [*2])
      else $error("read too soon"); // R7
   a_init_read_high: assert property (@(posedge core_clk) disable iff (!reset_n)
      !pins.init_pulse_n |-> pins.read_n && pins.write_n) else $error("strobe in init"); // R12
   a_replay_limit: assert property (@(posedge core_clk) disable iff (!reset_n)
      $fell(pins.load_replay_pin) && !chain_mode |-> q.writes <= 11'h400)
      else $error("replay past depth"); // R8
   c_write: cover property (@(posedge core_clk) $fell(pins.write_n));
   c_read: cover property (@(posedge core_clk) $fell(pins.read_n));
   c_replay: cover property (@(posedge core_clk) $fell(pins.load_replay_pin) && !chain_mode);
endmodule
`default_nettype wire

// ===== logic/fifo_host_pkg.sv
/*
 Package of the external FIFO host controller: register map, field
 positions, reset values, timing counts and carrier structs.
 Assumes a 40 MHz core clock and an APB slave with 32-bit data.
*/
package fifo_host_pkg;
   localparam int unsigned CLK_MHZ = 40;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] WDATA_OFS = 8'h04;
   localparam logic [7:0] RDATA_OFS = 8'h08;
   localparam logic [7:0] STAT_OFS = 8'h0c;
   localparam logic [7:0] WCNT_OFS = 8'h10;
   // CTRL fields
   localparam int CTRL_DEPTH_BIT = 0;
   localparam int CTRL_FIRST_BIT = 1;
   localparam int CTRL_INIT_BIT = 2;
   localparam int CTRL_REPLAY_BIT = 3;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   // Timing in ns, and cycle counts derived at the core clock rate
   localparam int unsigned STROBE_NS = 50;
   localparam int unsigned RECOVER_NS = 15;
   localparam int unsigned SETTLE_NS = 65;
   localparam int unsigned INIT_NS = 65;
   localparam int unsigned STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned RECOVER_CYC = (RECOVER_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned INIT_CYC = (INIT_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned MAX_REPLAY_WRITES = 1024;
   localparam int WORD_W = 9;

   // Pins toward the device (strobes active low)
   typedef struct packed {
      logic write_n;
      logic read_n;
      logic init_pulse_n;
      logic load_replay_pin;
      logic [WORD_W-1:0] wdata;
   } fifo_pins_t;

   typedef struct packed {
      logic empty_flag_n;
      logic full_flag_n;
      logic half_level_flag_n;
      logic [WORD_W-1:0] rdata;
   } fifo_status_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ASSERT = 3'b001,
      ST_RECOVER = 3'b011,
      ST_SETTLE = 3'b010,
      ST_INIT = 3'b110
   } seq_state_t;
endpackage

// ===== logic/write_log_mem.sv
/*
 Small memory of the last words written, used to compare replayed data.
 Assumes one write port and one registered read port on one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module write_log_mem #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input wire logic core_clk,
   input wire logic clk_en,
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   // No reset on storage; read data registered
   always_ff @(posedge core_clk) begin
      if (clk_en) begin
         if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
         end
         rd_data <= mem_q[rd_addr];
      end
   end
endmodule
`default_nettype wire

// ===== tb/async_fifo_flag_expansion_ctrl_test.sv
/*
 Self-checking bench of the FIFO host controller against the device model.
 Assumes a zero-wait APB slave and the package register map.
*/
`timescale 1ns/1ps
`default_nettype none
module async_fifo_flag_expansion_ctrl_test;
   logic core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic pready, pslverr, chain_mode, err, e_n, f_n, h_n;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic [8:0] dq;
   fifo_host_pkg::fifo_pins_t pins;
   int error_cnt = 0, cmp_count = 0, lrp_rise = 0;
   always #12.5 core_clk = ~core_clk;
   always @(posedge pins.load_replay_pin) lrp_rise++;

   fifo_host_ctrl #(.NDEV(1), .LOG_DEPTH(10)) DUT (.core_clk(core_clk), .reset_n(reset_n),
      .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .dev_empty_n(e_n), .dev_full_n(f_n), .half_level_flag_n(h_n), .dev_rdata(dq),
      .pins(pins), .chain_mode(chain_mode));
   fifo_dev_model MDL (.write_n(pins.write_n), .read_n(pins.read_n),
      .init_pulse_n(pins.init_pulse_n), .load_replay_pin(pins.load_replay_pin),
      .chain_in(chain_mode), .wdata(pins.wdata), .empty_flag_n(e_n), .full_flag_n(f_n),
      .half_level_flag_n(h_n), .rdata(dq));

   // ---------------------------------------------
   // Bus cycles and checking
   // ---------------------------------------------
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   // Polls status until idle; leaves the last status word in r
   task automatic idle();
      int n;
      repeat (2) @(posedge core_clk);
      for (n = 0; n < 100; n++) begin
         apb(1'b0, fifo_host_pkg::STAT_OFS, 32'h0);
         if (r[4] === 1'b0 && pins.init_pulse_n === 1'b1) break;
      end
      if (n == 100) error_cnt++;
   endtask
   task automatic wr(input int v);
      apb(1'b1, fifo_host_pkg::WDATA_OFS, 32'(v));
      idle();
   endtask
   // First access only launches a read; each later one returns the previous word
   task automatic rd_seq(input int n, input int first);
      apb(1'b0, fifo_host_pkg::RDATA_OFS, 32'h0);
      idle();
      for (int i = 0; i < n; i++) begin
         apb(1'b0, fifo_host_pkg::RDATA_OFS, 32'h0);
         chk("rdata", {22'h0, r[9:0]}, {22'h0, 1'b1, 9'(first + i)});
         idle();
      end
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset();
      chk("strobes", {29'h0, pins.write_n, pins.read_n, pins.init_pulse_n}, 32'h7);
      apb(1'b0, fifo_host_pkg::CTRL_OFS, 32'h0);
      chk("ctrl", r, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("slverr", {31'h0, err}, 32'h1);
   endtask
   task automatic t_fill();
      int s;
      apb(1'b1, fifo_host_pkg::CTRL_OFS, 32'h4);
      idle();
      chk("empty", {31'h0, r[1]}, 32'h0);
      for (int i = 0; i < 512; i++) wr(i);
      chk("half", {31'h0, r[3]}, 32'h1);
      wr(512);
      chk("half", {31'h0, r[3]}, 32'h0);
      for (int i = 513; i < 1024; i++) wr(i);
      chk("full", {31'h0, r[2]}, 32'h0);
      s = MDL.wr_strobes;
      wr(7);
      chk("strobes", 32'(MDL.wr_strobes), 32'(s));
   endtask
   task automatic t_replay();
      int s;
      rd_seq(3, 0);
      chk("replay_ok", {31'h0, r[5]}, 32'h1);
      s = lrp_rise;
      apb(1'b1, fifo_host_pkg::CTRL_OFS, 32'h8);
      idle();
      chk("pulse", 32'(lrp_rise), 32'(s + 1));
      chk("full", {31'h0, r[2]}, 32'h0);
      rd_seq(1024, 0);
      chk("replay_ok", {31'h0, r[5]}, 32'h1);
      chk("empty", {31'h0, r[1]}, 32'h0);
      for (int i = 0; i < 5; i++) wr(i + 100);
      rd_seq(5, 100);
   endtask
   task automatic t_depth();
      int s;
      apb(1'b1, fifo_host_pkg::CTRL_OFS, 32'h7);
      idle();
      chk("mode", {31'h0, chain_mode}, 32'h1);
      chk("first", {31'h0, pins.load_replay_pin}, 32'h0);
      wr(9);
      chk("half", {31'h0, r[3]}, 32'h1);
      s = lrp_rise;
      apb(1'b1, fifo_host_pkg::CTRL_OFS, 32'hb);
      idle();
      chk("pulse", 32'(lrp_rise), 32'(s));
      chk("first", {31'h0, pins.load_replay_pin}, 32'h0);
      rd_seq(1, 9);
   endtask

   task automatic finish_test();
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      t_reset();
      t_fill();
      t_replay();
      t_depth();
      finish_test();
   end
   // Run needs roughly 23k cycles; cut off at 50k
   initial begin
      #1250000;
      error_cnt++;
      finish_test();
   end
endmodule
`default_nettype wire

// ===== tb/fifo_dev_model.sv
/*
 Behavioural model of one 1024x9 asynchronous FIFO device, strobe-edge driven.
 Assumes the host drives the active-low strobes and the load/replay pin.
*/
`timescale 1ns/1ps
`default_nettype none
module fifo_dev_model (
   input wire logic write_n,
   input wire logic read_n,
   input wire logic init_pulse_n,
   input wire logic load_replay_pin,
   input wire logic chain_in,
   input wire logic [8:0] wdata,
   output logic empty_flag_n,
   output logic full_flag_n,
   output logic half_level_flag_n,
   output logic [8:0] rdata
);
   // ---------------------------------------------
   // Pointers, occupancy and flags
   // ---------------------------------------------
   logic [8:0] mem [1024];
   logic [9:0] wptr = 10'h000, rptr = 10'h000;
   logic [10:0] cnt = 11'h000, wtot = 11'h000;
   logic depth = 1'b0, wok = 1'b0, rok = 1'b0, act = 1'b1;
   logic [8:0] last = 9'h000;
   int wr_strobes = 0, chain_pulses = 0;
   always @(negedge init_pulse_n) begin
      wptr = 10'h000;
      rptr = 10'h000;
      cnt = 11'h000;
      wtot = 11'h000;
   end
   // Ring of one: act is set at init end unless depth mode without first_load, then holds until the next init
   always @(posedge init_pulse_n) begin
      depth = chain_in;
      act = !chain_in || !load_replay_pin;
   end
   always @(negedge write_n) begin
      wok = full_flag_n && act;
      wr_strobes++;
   end
   always @(posedge write_n) if (wok) begin
      mem[wptr] = wdata;
      if (depth && wptr == 10'h3ff) chain_pulses++;
      wptr++;
      cnt++;
      wtot++;
   end
   always @(negedge read_n) rok = empty_flag_n && act;
   always @(posedge read_n) if (rok) begin
      last = mem[rptr];
      if (depth && rptr == 10'h3ff) chain_pulses++;
      rptr++;
      cnt--;
   end
   // Replay ignored in depth mode; occupancy rebuilt from writes since init
   always @(negedge load_replay_pin) if (init_pulse_n && !depth) begin
      rptr = 10'h000;
      cnt = wtot;
   end
   assign empty_flag_n = cnt != 11'h000;
   assign full_flag_n = cnt != 11'h400;
   // Zero-delay flags: already settled when the host samples
   assign half_level_flag_n = depth || cnt < 11'h201;
   // Released bus shows the inverse so stale data never matches
   assign rdata = read_n ? ~last : mem[rptr];
endmodule
`default_nettype wire
